// File: rtl/ctt_pkg.sv
// Shared constants and types for the core tick timer block.
package ctt_pkg;
    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int CTT_W = 32;
    localparam int CTT_HWR_N = 4;
    localparam logic [31:0] CTT_COUNT_RST = 32'h0000_0000;
    localparam logic [31:0] CTT_CMP_RST = 32'hFFFF_FFFF;
    localparam logic [3:0] CTT_MASK_RST = 4'h0;
    // ------------------------------------------------------------------
    // System coprocessor register selectors
    // ------------------------------------------------------------------
    localparam logic [2:0] CTT_SEL_COUNT = 3'h0;
    localparam logic [2:0] CTT_SEL_CMP = 3'h1;
    localparam logic [2:0] CTT_SEL_MASK = 3'h2;
    localparam logic [2:0] CTT_SEL_HALT = 3'h3;
    localparam logic [2:0] CTT_SEL_DBG = 3'h4;
    // Hardware register index of the tick counter for user reads.
    localparam logic [1:0] CTT_HWR_COUNT = 2'h2;
    // Counter advances once per this many core clocks.
    localparam int CTT_TICK_DIV = 2;
    typedef enum logic [1:0] {CTT_ACC_NONE, CTT_ACC_READ, CTT_ACC_WRITE} ctt_acc_t;
endpackage

// File: rtl/ctt_cnt_if.sv
// Interface joining the tick counter core to the top module.
`timescale 1ns/1ps
interface ctt_cnt_if;
    logic wr_count;
    logic [31:0] wr_data;
    logic run;
    logic [31:0] count;
    logic tick;
    modport core (
        input wr_count,
        input wr_data,
        input run,
        output count,
        output tick
    );
    modport ctrl (
        output wr_count,
        output wr_data,
        output run,
        input count,
        input tick
    );
endinterface

// File: rtl/ctt_counter.sv
// Tick counter that advances every second core clock.
`timescale 1ns/1ps
module ctt_counter #(
    parameter int W = ctt_pkg::CTT_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Counter control and state
    ctt_cnt_if.core cif
);
    logic phase_r;
    logic phase_nxt;
    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;
    logic adv;

    // The phase toggles regardless of the pipeline, so the rate is fixed.
    assign adv = cif.run && phase_r;
    assign phase_nxt = cif.run ? ~phase_r : phase_r;
    // A write wins over an advance; counting resumes from the written value.
    assign count_nxt = cif.wr_count ? cif.wr_data[W-1:0] :
                       adv ? count_r + W'(1) : count_r;
    assign cif.count = count_r;
    assign cif.tick = adv;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            phase_r <= 1'b0;
            count_r <= W'(ctt_pkg::CTT_COUNT_RST);
        end else begin
            phase_r <= cif.wr_count ? 1'b0 : phase_nxt;
            count_r <= count_nxt;
        end
    end

    AST_HOLD_WHEN_HALTED: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!cif.run && !cif.wr_count) |=> $stable(count_r))
        else $error("Counter moved while halted.");
    AST_WRITE_LOADS: assert property (@(posedge ref_clk) disable iff (!nrst)
        cif.wr_count |=> count_r == $past(cif.wr_data))
        else $error("Counter write not loaded.");
endmodule

// File: rtl/ctt_timer.sv
// Core tick timer: counter, compare, match output and user read gating.
`timescale 1ns/1ps
// What this block does
// - Counter rate independent of instruction progress
// - Halt bit clear: increment every second clock
// - Halt bit set: counter holds its value
// - Counter writable anytime; counting continues from it
// - Debug bit selects counting in debug mode
// - Compare holds last written value only
// - Counter equal compare asserts match output
// - Match stays asserted until compare written
// - Compare write clears pending match
// - Compare register readable for diagnostics
// - Match output routable to core interrupt input
// - Access mask gates user hardware reads
module ctt_timer #(
    parameter int W = ctt_pkg::CTT_W,
    parameter int HWR_N = ctt_pkg::CTT_HWR_N
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // System coprocessor moves, privileged
    input wire logic cop_wr,
    input wire logic cop_rd,
    input wire logic [2:0] cop_sel,
    input wire logic [31:0] cop_wdata,
    output logic [31:0] cop_rdata,
    // User hardware register reads
    input wire logic hwr_rd,
    input wire logic [1:0] hwr_idx,
    input wire logic user_mode,
    output logic [31:0] hwr_rdata,
    output logic hwr_ri_exc,
    // Core state
    input wire logic debug_mode,
    // Timer interrupt
    output logic timer_match_irq
);
    ctt_cnt_if cif ();

    logic counter_halt_bit_r;
    logic debug_tick_enable_r;
    logic [W-1:0] cmp_r;
    logic [HWR_N-1:0] hw_reg_access_mask_r;
    logic irq_r;
    logic irq_nxt;
    logic [31:0] cop_rdata_r;
    logic [31:0] cop_rdata_nxt;
    logic [31:0] hwr_rdata_r;
    logic [31:0] hwr_rdata_nxt;
    logic ri_r;
    logic ri_nxt;
    logic wr_cmp;
    logic wr_mask;
    logic wr_halt;
    logic wr_dbg;
    logic match;
    logic hwr_ok;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    function automatic logic sel_hit(input logic en, input logic [2:0] s, input logic [2:0] t);
        return en && (s == t);
    endfunction

    assign cif.wr_count = sel_hit(cop_wr, cop_sel, ctt_pkg::CTT_SEL_COUNT);
    assign cif.wr_data = cop_wdata;
    assign wr_cmp = sel_hit(cop_wr, cop_sel, ctt_pkg::CTT_SEL_CMP);
    assign wr_mask = sel_hit(cop_wr, cop_sel, ctt_pkg::CTT_SEL_MASK);
    assign wr_halt = sel_hit(cop_wr, cop_sel, ctt_pkg::CTT_SEL_HALT);
    assign wr_dbg = sel_hit(cop_wr, cop_sel, ctt_pkg::CTT_SEL_DBG);
    // Debug mode stops the counter only when the debug bit says so.
    assign cif.run = !counter_halt_bit_r && (!debug_mode || debug_tick_enable_r);

    ctt_counter #(.W(W)) u_cnt (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .cif(cif)
    );

    // ------------------------------------------------------------------
    // Compare and match
    // ------------------------------------------------------------------
    // The compare being overwritten must not raise a match in the write cycle.
    assign match = (cif.count == cmp_r) && !wr_cmp;
    // Match sets and holds; only a compare write clears it. A match landing in
    // the write cycle is against the old value and is dropped on purpose.
    assign irq_nxt = wr_cmp ? 1'b0 : (irq_r || match);

    // ------------------------------------------------------------------
    // Read paths
    // ------------------------------------------------------------------
    always_comb begin
        case (cop_sel)
            ctt_pkg::CTT_SEL_COUNT: cop_rdata_nxt = cif.count;
            ctt_pkg::CTT_SEL_CMP: cop_rdata_nxt = cmp_r;
            ctt_pkg::CTT_SEL_MASK: cop_rdata_nxt = {{(32-HWR_N){1'b0}}, hw_reg_access_mask_r};
            ctt_pkg::CTT_SEL_HALT: cop_rdata_nxt = {31'h0000_0000, counter_halt_bit_r};
            ctt_pkg::CTT_SEL_DBG: cop_rdata_nxt = {31'h0000_0000, debug_tick_enable_r};
            default: cop_rdata_nxt = 32'h0000_0000;
        endcase
        if (!cop_rd) begin
            cop_rdata_nxt = cop_rdata_r;
        end
    end

    // Kernel code always reads; user code only where the mask bit is set.
    assign hwr_ok = !user_mode || hw_reg_access_mask_r[hwr_idx];
    assign ri_nxt = hwr_rd && !hwr_ok;
    assign hwr_rdata_nxt = !(hwr_rd && hwr_ok) ? hwr_rdata_r :
                           (hwr_idx == ctt_pkg::CTT_HWR_COUNT) ? cif.count : 32'h0000_0000;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            counter_halt_bit_r <= 1'b0;
            debug_tick_enable_r <= 1'b0;
            hw_reg_access_mask_r <= HWR_N'(ctt_pkg::CTT_MASK_RST);
            cmp_r <= W'(ctt_pkg::CTT_CMP_RST);
        end else begin
            if (wr_halt) counter_halt_bit_r <= cop_wdata[0];
            if (wr_dbg) debug_tick_enable_r <= cop_wdata[0];
            if (wr_mask) hw_reg_access_mask_r <= cop_wdata[HWR_N-1:0];
            if (wr_cmp) cmp_r <= cop_wdata[W-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_r <= 1'b0;
            cop_rdata_r <= 32'h0000_0000;
            hwr_rdata_r <= 32'h0000_0000;
            ri_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
            cop_rdata_r <= cop_rdata_nxt;
            hwr_rdata_r <= hwr_rdata_nxt;
            ri_r <= ri_nxt;
        end
    end

    assign timer_match_irq = irq_r;
    assign cop_rdata = cop_rdata_r;
    assign hwr_rdata = hwr_rdata_r;
    assign hwr_ri_exc = ri_r;

    // ------------------------------------------------------------------
    // Check helpers
    // ------------------------------------------------------------------
    // Run edges taken since the last advance or counter write. It is kept
    // apart from the counter's own phase bit so that the checks below do
    // not simply repeat the logic that they guard.
    // It saturates rather than wraps, so a stuck counter keeps failing.
    logic [1:0] gap_r;
    logic [1:0] gap_nxt;
    logic gap_clr;
    logic gap_inc;

    assign gap_clr = cif.wr_count || cif.tick;
    assign gap_inc = cif.run && (gap_r != 2'h3);
    assign gap_nxt = gap_clr ? 2'h0 : (gap_inc ? gap_r + 2'h1 : gap_r);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            gap_r <= 2'h0;
        end else begin
            gap_r <= gap_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_step_pair;
        !cif.wr_count && cif.run ##1 !cif.wr_count && cif.run;
    endsequence

    AST_TWO_CLOCK_STEP: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_step_pair |=> (cif.count - $past(cif.count, 2)) == 32'h0000_0001)
        else $error("Counter did not advance once per two clocks.");
    AST_HALT_HOLDS: assert property (@(posedge ref_clk) disable iff (!nrst)
        (counter_halt_bit_r && !cif.wr_count) |=> $stable(cif.count))
        else $error("Counter moved with halt bit set.");
    AST_DEBUG_STOP: assert property (@(posedge ref_clk) disable iff (!nrst)
        (debug_mode && !debug_tick_enable_r && !cif.wr_count) |=> $stable(cif.count))
        else $error("Counter moved in debug mode while disabled.");
    AST_CMP_STABLE: assert property (@(posedge ref_clk) disable iff (!nrst)
        !wr_cmp |=> $stable(cmp_r))
        else $error("Compare changed without a write.");
    AST_MATCH_RAISES: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cif.count == cmp_r && !wr_cmp) |=> timer_match_irq)
        else $error("Match did not raise the interrupt.");
    AST_IRQ_STICKY: assert property (@(posedge ref_clk) disable iff (!nrst)
        (timer_match_irq && !wr_cmp) |=> timer_match_irq)
        else $error("Interrupt dropped without a compare write.");
    AST_CMP_WRITE_CLEARS: assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_cmp |=> !timer_match_irq && cmp_r == $past(cop_wdata))
        else $error("Compare write did not store and clear.");
    AST_CMP_READBACK: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cop_rd && cop_sel == ctt_pkg::CTT_SEL_CMP) |=> cop_rdata == $past(cmp_r))
        else $error("Compare readback wrong.");
    AST_MASKED_TRAPS: assert property (@(posedge ref_clk) disable iff (!nrst)
        (hwr_rd && user_mode && !hw_reg_access_mask_r[hwr_idx]) |=> hwr_ri_exc)
        else $error("Masked user read did not trap.");

    // ------------------------------------------------------------------
    // Counter rate checks
    // ------------------------------------------------------------------
    // An advance must close a pair of run edges, never open one.
    AST_TICK_CLOSES_PAIR: assert property (@(posedge ref_clk) disable iff (!nrst)
        cif.tick
        |-> gap_r == 2'(ctt_pkg::CTT_TICK_DIV - 1))
        else $error("Counter advanced without a run edge before it.");
    AST_FIRST_HALF_WAITS: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cif.run && !cif.tick)
        |-> gap_r == 2'h0)
        else $error("Counter skipped an advance.");
    AST_TICK_ADDS_ONE: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cif.tick && !cif.wr_count)
        |=> cif.count == $past(cif.count) + 32'h0000_0001)
        else $error("Counter advance was not one.");
    AST_ONLY_TICK_MOVES: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!cif.tick && !cif.wr_count)
        |=> $stable(cif.count))
        else $error("Counter moved without an advance.");
    // Counting resumes from the written value, so the first advance after a
    // write is a whole pair of run edges away.
    AST_WRITE_RESTARTS_PAIR: assert property (@(posedge ref_clk) disable iff (!nrst)
        cif.wr_count
        |=> !cif.tick)
        else $error("Counter advanced straight after a write.");
    // Nothing but the halt bit and the debug controls may stop the count, so
    // stalls elsewhere in the core cannot change the rate.
    AST_RUNS_WHEN_FREE: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!counter_halt_bit_r && !debug_mode)
        |-> cif.run)
        else $error("Counter stopped although nothing halts it.");
    AST_DEBUG_KEEPS_RUNNING: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!counter_halt_bit_r && debug_mode && debug_tick_enable_r)
        |-> cif.run)
        else $error("Counter stopped in debug mode while enabled.");
    AST_WRAP_SILENT: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cif.tick && !cif.wr_count && cif.count == 32'hFFFF_FFFF)
        |=> cif.count == 32'h0000_0000)
        else $error("Counter did not wrap to zero.");

    // ------------------------------------------------------------------
    // Interrupt checks
    // ------------------------------------------------------------------
    sequence s_pending_kept;
        timer_match_irq && !wr_cmp;
    endsequence
    sequence s_moved_past;
        !wr_cmp && cif.count != cmp_r;
    endsequence
    sequence s_fresh_compare;
        wr_cmp ##1 match;
    endsequence

    AST_IRQ_NEEDS_MATCH: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(timer_match_irq)
        |-> $past(match))
        else $error("Interrupt rose without a match.");
    // The line must outlast the counter running on past the match value.
    AST_IRQ_OUTLASTS_MATCH: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_pending_kept ##1 s_moved_past
        |=> timer_match_irq)
        else $error("Interrupt dropped once the counter moved on.");
    AST_NEW_COMPARE_REARMS: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_fresh_compare
        |=> timer_match_irq)
        else $error("Match after a compare write was lost.");

    // ------------------------------------------------------------------
    // Read checks
    // ------------------------------------------------------------------
    AST_COUNT_READBACK: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cop_rd && cop_sel == ctt_pkg::CTT_SEL_COUNT)
        |=> cop_rdata == $past(cif.count))
        else $error("Counter readback wrong.");
    AST_RDATA_HOLDS: assert property (@(posedge ref_clk) disable iff (!nrst)
        !cop_rd
        |=> $stable(cop_rdata))
        else $error("Read data changed without a read.");
    AST_USER_COUNT_READ: assert property (@(posedge ref_clk) disable iff (!nrst)
        (hwr_rd && hwr_idx == ctt_pkg::CTT_HWR_COUNT &&
            (!user_mode || hw_reg_access_mask_r[hwr_idx]))
        |=> hwr_rdata == $past(cif.count))
        else $error("Permitted counter read returned wrong data.");
    // A refused read must leave the last good data for the trap handler.
    AST_REFUSED_KEEPS_DATA: assert property (@(posedge ref_clk) disable iff (!nrst)
        (hwr_rd && user_mode && !hw_reg_access_mask_r[hwr_idx])
        |=> $stable(hwr_rdata))
        else $error("Refused read changed the data.");
    AST_KERNEL_NO_TRAP: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!hwr_rd || !user_mode)
        |=> !hwr_ri_exc)
        else $error("Trap raised for a permitted read.");
endmodule

// File: dv/ctt_irq_sink.sv
// Model of the core interrupt input that the timer match line feeds.
`timescale 1ns/1ps
module ctt_irq_sink (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Match line from the timer
    input wire logic irq_line,
    // Sampled request and count of new requests
    output logic pend_r,
    output logic [15:0] rises_r
);
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pend_r <= 1'b0;
            rises_r <= 16'h0000;
        end else begin
            pend_r <= irq_line;
            if (irq_line && !pend_r) begin
                rises_r <= rises_r + 16'h0001;
            end
        end
    end
endmodule

// File: dv/core_tick_timer_compare_bench.sv
// Self-checking bench for the core tick timer against a cycle model.
`timescale 1ns/1ps
module core_tick_timer_compare_bench;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic cop_wr, cop_rd, hwr_rd, user_mode, debug_mode, hwr_ri_exc, timer_match_irq;
    logic [2:0] cop_sel;
    logic [1:0] hwr_idx;
    logic [31:0] cop_wdata, cop_rdata, hwr_rdata, rv, m_cnt, m_cmp, m_rd, m_hrd;
    logic [15:0] sink_rises;
    logic [3:0] m_mask;
    logic m_halt, m_dbg, m_ph, m_irq, m_exc, m_run;
    int n_errors = 0;
    int num_checks = 0;
    int seed = 76116;
    int cycles = 0;
    int m_rises = 0;

    always #50 ref_clk = ~ref_clk;

    ctt_timer ctt_timer_inst (.ref_clk(ref_clk), .nrst(nrst), .cop_wr(cop_wr), .cop_rd(cop_rd),
        .cop_sel(cop_sel), .cop_wdata(cop_wdata), .cop_rdata(cop_rdata), .hwr_rd(hwr_rd),
        .hwr_idx(hwr_idx), .user_mode(user_mode), .hwr_rdata(hwr_rdata),
        .hwr_ri_exc(hwr_ri_exc), .debug_mode(debug_mode), .timer_match_irq(timer_match_irq));
    ctt_irq_sink ctt_irq_sink_inst (.ref_clk(ref_clk), .nrst(nrst), .irq_line(timer_match_irq),
        .pend_r(), .rises_r(sink_rises));

    // ----------------------------------------------------------------
    // Reference model
    // ----------------------------------------------------------------
    function automatic logic [31:0] sel_val(input logic [2:0] s);
        case (s)
            ctt_pkg::CTT_SEL_COUNT: sel_val = m_cnt;
            ctt_pkg::CTT_SEL_CMP: sel_val = m_cmp;
            ctt_pkg::CTT_SEL_MASK: sel_val = {28'h000_0000, m_mask};
            ctt_pkg::CTT_SEL_HALT: sel_val = {31'h0000_0000, m_halt};
            ctt_pkg::CTT_SEL_DBG: sel_val = {31'h0000_0000, m_dbg};
            default: sel_val = 32'h0000_0000;
        endcase
    endfunction

    // Every value is taken from the state before the edge, as the registers see it.
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            m_cnt = ctt_pkg::CTT_COUNT_RST;
            m_cmp = ctt_pkg::CTT_CMP_RST;
            m_mask = ctt_pkg::CTT_MASK_RST;
            {m_rd, m_hrd, m_halt, m_dbg, m_ph, m_irq, m_exc} = '0;
        end else begin
            cycles++;
            m_run = !m_halt && (!debug_mode || m_dbg);
            if (cop_wr && cop_sel == ctt_pkg::CTT_SEL_CMP) begin
                m_irq = 1'b0;
            end else if (m_cnt == m_cmp && !m_irq) begin
                m_irq = 1'b1;
                m_rises++;
            end
            if (cop_rd) begin
                m_rd = sel_val(cop_sel);
            end
            m_exc = hwr_rd && user_mode && !m_mask[hwr_idx];
            if (hwr_rd && !m_exc) begin
                m_hrd = (hwr_idx == ctt_pkg::CTT_HWR_COUNT) ? m_cnt : 32'h0000_0000;
            end
            if (cop_wr && cop_sel == ctt_pkg::CTT_SEL_COUNT) begin
                m_cnt = cop_wdata;
                m_ph = 1'b0;
            end else if (m_run) begin
                m_cnt = m_cnt + {31'h0000_0000, m_ph};
                m_ph = !m_ph;
            end
            if (cop_wr) begin
                case (cop_sel)
                    ctt_pkg::CTT_SEL_CMP: m_cmp = cop_wdata;
                    ctt_pkg::CTT_SEL_MASK: m_mask = cop_wdata[3:0];
                    ctt_pkg::CTT_SEL_HALT: m_halt = cop_wdata[0];
                    ctt_pkg::CTT_SEL_DBG: m_dbg = cop_wdata[0];
                    default: ;
                endcase
            end
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        #1;
        chk("cop_rdata", m_rd, cop_rdata);
        chk("hwr_rdata", m_hrd, hwr_rdata);
        chk("hwr_ri_exc", {31'h0000_0000, m_exc}, {31'h0000_0000, hwr_ri_exc});
        chk("irq", {31'h0000_0000, m_irq}, {31'h0000_0000, timer_match_irq});
        if (cycles >= 3000) begin
            n_errors++;
            $display("[FAIL] cycle limit expected 3000 seen %0d", cycles);
            conclude();
        end
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    task automatic step(input logic w, input logic r, input logic [2:0] s,
            input logic [31:0] d, input logic h, input logic [1:0] i, input logic u);
        cop_wr = w;
        cop_rd = r;
        cop_sel = s;
        cop_wdata = d;
        hwr_rd = h;
        hwr_idx = i;
        user_mode = u;
        @(negedge ref_clk);
    endtask
    task automatic wr(input logic [2:0] s, input logic [31:0] d);
        step(1'b1, 1'b0, s, d, 1'b0, 2'h0, 1'b0);
    endtask
    // Idle cycles read the counter so that every tick is compared.
    task automatic idle(input int n);
        repeat (n) step(1'b0, 1'b1, ctt_pkg::CTT_SEL_COUNT, 32'h0000_0000, 1'b0, 2'h0, 1'b0);
    endtask

    initial begin
        debug_mode = 1'b0;
        step(1'b0, 1'b0, 3'h0, 32'h0000_0000, 1'b0, 2'h0, 1'b0);
        repeat (3) @(negedge ref_clk);
        nrst = 1'b1;
        for (int s = 0; s < 8; s++) step(1'b0, 1'b1, s[2:0], 32'h0000_0000, 1'b0, 2'h0, 1'b0);
        wr(ctt_pkg::CTT_SEL_COUNT, 32'h0000_0000);
        wr(ctt_pkg::CTT_SEL_CMP, 32'h0000_0010);
        idle(40);
        wr(ctt_pkg::CTT_SEL_CMP, 32'h0000_0000);
        $display("test count and match done");
        wr(ctt_pkg::CTT_SEL_HALT, 32'h0000_0001);
        idle(6);
        wr(ctt_pkg::CTT_SEL_HALT, 32'h0000_0000);
        debug_mode = 1'b1;
        idle(6);
        wr(ctt_pkg::CTT_SEL_DBG, 32'h0000_0001);
        idle(6);
        debug_mode = 1'b0;
        $display("test halt and debug done");
        wr(ctt_pkg::CTT_SEL_COUNT, 32'hFFFF_FFFE);
        wr(ctt_pkg::CTT_SEL_CMP, 32'h0000_0001);
        idle(10);
        wr(ctt_pkg::CTT_SEL_CMP, 32'h0000_0100);
        wr(ctt_pkg::CTT_SEL_COUNT, 32'h0000_0100);
        wr(ctt_pkg::CTT_SEL_CMP, 32'h0000_0100);
        idle(6);
        $display("test wrap and compare write done");
        for (int m = 0; m < 2; m++) begin
            wr(ctt_pkg::CTT_SEL_MASK, m ? 32'h0000_0004 : 32'h0000_0000);
            for (int i = 0; i < 8; i++) step(1'b0, 1'b0, 3'h0, 32'h0000_0000, 1'b1, i[1:0], i[2]);
        end
        $display("test user reads done");
        for (int k = 0; k < 400; k++) begin
            rv = $random(seed);
            debug_mode = (rv[13:11] == 3'h0);
            step(rv[2:0] == 3'h0, rv[3], rv[6:4], {26'h000_0000, rv[21:16]}, rv[7], rv[9:8], rv[10]);
        end
        idle(4);
        chk("irq requests", m_rises, {16'h0000, sink_rises});
        $display("test random traffic done");
        step(1'b0, 1'b0, 3'h0, 32'h0000_0000, 1'b0, 2'h0, 1'b0);
        nrst = 1'b0;
        repeat (2) @(negedge ref_clk);
        nrst = 1'b1;
        idle(6);
        $display("test second reset done");
        conclude();
    end
endmodule
